// [design/sfq_fifo.sv]
// common-clock 16 x 16 fifo with quadrant direction flag and apb status slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`default_nettype none

`include "sfq_cfg.svh"

// What this block does
// - sixteen 16-bit words, one clock, two enables
// - enabled write stores word, advances write counter
// - output shows read-address word, advances on read
// - counters: two cascaded 2-bit gray stages
// - upper bits hold for four counts, no lfsr
// - full when sixteen unread words held
// - empty when everything written was read
// - equal addresses: direction flag picks full/empty
// - quadrant index from both counters' top bits
// - write quadrant just behind read sets direction
// - write quadrant just ahead of read clears
// - same or opposite quadrants keep direction
// - direction starts cleared with counters at zero
// - full rises on filling write, falls on read
// - empty rises on draining read, falls on write
module sfq_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire sfq_pkg::sfq_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sfq_pkg::sfq_wr_t wr,
  input wire logic rd_en,
  output logic [`SFQ_DATA_W-1:0] rd_data,
  output logic full,
  output logic empty,
  output logic irq
);
  import sfq_pkg::*;

  sfq_state_t st_ff;
  sfq_state_t nxt_st;

  // ----------------------------------------------------------------------------
  // counter stage
  // ----------------------------------------------------------------------------
  // each 4-bit counter is a low gray stage whose carry steps the high stage
  logic wr_go;
  logic rd_go;
  logic [1:0] wr_lo_nx;
  logic [1:0] wr_hi_nx;
  logic [1:0] rd_lo_nx;
  logic [1:0] rd_hi_nx;
  logic wr_lo_carry;
  logic rd_lo_carry;

  // refusing out-of-turn enables protects the pointers if the outside slips
  assign wr_go = wr.en & ~st_ff.full;
  assign rd_go = rd_en & ~st_ff.empty;

  sfq_gray2 u_wr_lo (
    .cur(st_ff.wr_lo),
    .step(wr_go),
    .nxt(wr_lo_nx),
    .carry(wr_lo_carry)
  );
  sfq_gray2 u_wr_hi (
    .cur(st_ff.wr_hi),
    .step(wr_lo_carry),
    .nxt(wr_hi_nx),
    .carry()
  );
  sfq_gray2 u_rd_lo (
    .cur(st_ff.rd_lo),
    .step(rd_go),
    .nxt(rd_lo_nx),
    .carry(rd_lo_carry)
  );
  sfq_gray2 u_rd_hi (
    .cur(st_ff.rd_hi),
    .step(rd_lo_carry),
    .nxt(rd_hi_nx),
    .carry()
  );

  // ----------------------------------------------------------------------------
  // quadrant decode
  // ----------------------------------------------------------------------------
  // index is {write top stage, read top stage}; result is {set, clear}
  // same and opposite quadrants say nothing, so both stay low there
  function automatic logic [1:0] quad_lut(input logic [3:0] idx);
    logic s;
    logic c;
    s = 1'b0;
    c = 1'b0;
    unique case (idx)
      4'h0: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'h1: begin
        s = 1'b1;
        c = 1'b0;
      end
      4'h2: begin
        s = 1'b0;
        c = 1'b1;
      end
      4'h3: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'h4: begin
        s = 1'b0;
        c = 1'b1;
      end
      4'h5: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'h6: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'h7: begin
        s = 1'b1;
        c = 1'b0;
      end
      4'h8: begin
        s = 1'b1;
        c = 1'b0;
      end
      4'h9: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'hA: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'hB: begin
        s = 1'b0;
        c = 1'b1;
      end
      4'hC: begin
        s = 1'b0;
        c = 1'b0;
      end
      4'hD: begin
        s = 1'b0;
        c = 1'b1;
      end
      4'hE: begin
        s = 1'b1;
        c = 1'b0;
      end
      4'hF: begin
        s = 1'b0;
        c = 1'b0;
      end
    endcase
    return {s, c};
  endfunction

  // ----------------------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------------------
  // result is {address known, read word}; unused bits read zero
  function automatic logic [32:0] reg_read(input logic [`SFQ_PADDR_W-1:0] a,
                                           input sfq_state_t s);
    logic ok;
    logic [31:0] v;
    ok = 1'b0;
    v = 32'h0000_0000;
    unique case (a)
      `SFQ_CTRL_OFS: begin
        ok = 1'b1;
      end
      `SFQ_STAT_OFS: begin
        ok = 1'b1;
        v[`SFQ_STAT_EMPTY_BIT] = s.empty;
        v[`SFQ_STAT_FULL_BIT] = s.full;
        v[`SFQ_STAT_DIR_BIT] = s.dir;
        v[`SFQ_STAT_WPTR_LSB +: `SFQ_ADDR_W] = {s.wr_hi, s.wr_lo};
        v[`SFQ_STAT_RPTR_LSB +: `SFQ_ADDR_W] = {s.rd_hi, s.rd_lo};
      end
      `SFQ_IRQ_STAT_OFS: begin
        ok = 1'b1;
        v[`SFQ_IRQ_W-1:0] = s.irq_stat;
      end
      `SFQ_IRQ_MASK_OFS: begin
        ok = 1'b1;
        v[`SFQ_IRQ_W-1:0] = s.irq_mask;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return {ok, v};
  endfunction

  // ----------------------------------------------------------------------------
  // events
  // ----------------------------------------------------------------------------
  // a flush is not a drain, so it raises no empty event
  function automatic logic [`SFQ_IRQ_W-1:0] make_events(input sfq_state_t cur,
                                                        input sfq_state_t nx,
                                                        input logic we,
                                                        input logic re,
                                                        input logic fl);
    logic [`SFQ_IRQ_W-1:0] e;
    e = '0;
    e[`SFQ_IRQ_FULL_BIT] = nx.full & ~cur.full;
    e[`SFQ_IRQ_EMPTY_BIT] = nx.empty & ~cur.empty & ~fl;
    e[`SFQ_IRQ_OVF_BIT] = we & cur.full;
    e[`SFQ_IRQ_UNF_BIT] = re & cur.empty;
    return e;
  endfunction

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic setup;
    logic [1:0] quad;
    logic [32:0] rsp;
    logic access;
    logic addr_ok;
    logic flush;
    logic ptr_eq;
    logic [`SFQ_IRQ_W-1:0] ev;
    logic [31:0] rdv;
    nxt_st = st_ff;
    setup = 1'b0;
    quad = 2'h0;
    rsp = 33'h0_0000_0000;
    access = 1'b0;
    addr_ok = 1'b0;
    flush = 1'b0;
    ptr_eq = 1'b0;
    ev = '0;
    rdv = 32'h0000_0000;

    // apb decode; a transfer completes in the first access cycle
    setup = apb.psel & ~apb.penable;
    access = apb.psel & apb.penable & st_ff.pready;
    rsp = reg_read(apb.paddr, st_ff);
    addr_ok = rsp[32];
    rdv = rsp[31:0];
    nxt_st.pready = setup;
    if (setup) begin
      nxt_st.prdata = apb.pwrite ? 32'h0000_0000 : rdv;
      nxt_st.pslverr = ~addr_ok;
    end
    if (access && apb.pwrite && addr_ok) begin
      if (apb.paddr == `SFQ_CTRL_OFS) begin
        flush = apb.pwdata[`SFQ_CTRL_FLUSH_BIT];
      end
      if (apb.paddr == `SFQ_IRQ_MASK_OFS) begin
        nxt_st.irq_mask = apb.pwdata[`SFQ_IRQ_W-1:0];
      end
    end

    // ------------------------------------------------------------------------
    // data store and counters
    // ------------------------------------------------------------------------
    if (wr_go) begin
      nxt_st.mem[{st_ff.wr_hi, st_ff.wr_lo}] = wr.data;
    end
    nxt_st.wr_lo = wr_lo_nx;
    nxt_st.wr_hi = wr_hi_nx;
    nxt_st.rd_lo = rd_lo_nx;
    nxt_st.rd_hi = rd_hi_nx;

    // ------------------------------------------------------------------------
    // direction flag
    // ------------------------------------------------------------------------
    // decoded from the counters after the edge, so the flags of that same edge already see it
    quad = quad_lut({nxt_st.wr_hi, nxt_st.rd_hi});
    if (quad[1]) begin
      nxt_st.dir = 1'b1;
    end else if (quad[0]) begin
      nxt_st.dir = 1'b0;
    end else begin
      nxt_st.dir = st_ff.dir;
    end

    if (flush) begin
      nxt_st.wr_hi = `SFQ_GRAY_ZERO;
      nxt_st.wr_lo = `SFQ_GRAY_ZERO;
      nxt_st.rd_hi = `SFQ_GRAY_ZERO;
      nxt_st.rd_lo = `SFQ_GRAY_ZERO;
      nxt_st.dir = 1'b0;
    end

    // flags follow the edge that changes the counters
    ptr_eq = {nxt_st.wr_hi, nxt_st.wr_lo} == {nxt_st.rd_hi, nxt_st.rd_lo};
    nxt_st.full = ptr_eq & nxt_st.dir;
    nxt_st.empty = ptr_eq & ~nxt_st.dir;

    // the next word is looked up ahead so it shows right after the edge
    nxt_st.dout = nxt_st.mem[{nxt_st.rd_hi, nxt_st.rd_lo}];

    // events; a read of the status clears it but a new event wins
    ev = make_events(st_ff, nxt_st, wr.en, rd_en, flush);
    if (access && !apb.pwrite && apb.paddr == `SFQ_IRQ_STAT_OFS) begin
      nxt_st.irq_stat = '0;
    end
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
  end

  // ----------------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.wr_hi <= `SFQ_GRAY_ZERO;
      st_ff.wr_lo <= `SFQ_GRAY_ZERO;
      st_ff.rd_hi <= `SFQ_GRAY_ZERO;
      st_ff.rd_lo <= `SFQ_GRAY_ZERO;
      st_ff.dir <= 1'b0;
      st_ff.full <= 1'b0;
      st_ff.empty <= `SFQ_EMPTY_RST;
      st_ff.irq_mask <= `SFQ_IRQ_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign rd_data = st_ff.dout;
  assign full = st_ff.full;
  assign empty = st_ff.empty;
  assign irq = st_ff.irq;
endmodule

// ----------------------------------------------------------------------------
// one 2-bit gray counting stage
// ----------------------------------------------------------------------------
// only one bit moves per step, so the quadrant decode never glitches
module sfq_gray2 #(
  parameter logic [1:0] CARRY_FROM = 2'h2
) (
  input wire logic [1:0] cur,
  input wire logic step,
  output logic [1:0] nxt,
  output logic carry
);
  function automatic logic [1:0] gray_inc(input logic [1:0] g);
    logic [1:0] r;
    r = `SFQ_GRAY_ZERO;
    unique case (g)
      2'h0: r = 2'h1;
      2'h1: r = 2'h3;
      2'h3: r = 2'h2;
      2'h2: r = 2'h0;
    endcase
    return r;
  endfunction

  // the last code of the stage hands its step on to the next stage
  assign nxt = step ? gray_inc(cur) : cur;
  assign carry = step & (cur == CARRY_FROM);
endmodule

`default_nettype wire

// [design/sfq_cfg.svh]
// offsets, field positions, reset values and sizes of the common-clock fifo
`ifndef SFQ_CFG_SVH
`define SFQ_CFG_SVH

// ----------------------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------------------
`define SFQ_DATA_W 16
`define SFQ_DEPTH 16
`define SFQ_ADDR_W 4
`define SFQ_PADDR_W 12

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SFQ_CTRL_OFS 12'h000
`define SFQ_STAT_OFS 12'h004
`define SFQ_IRQ_STAT_OFS 12'h008
`define SFQ_IRQ_MASK_OFS 12'h00C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define SFQ_CTRL_FLUSH_BIT 0
`define SFQ_STAT_EMPTY_BIT 0
`define SFQ_STAT_FULL_BIT 1
`define SFQ_STAT_DIR_BIT 2
`define SFQ_STAT_WPTR_LSB 8
`define SFQ_STAT_RPTR_LSB 12
`define SFQ_IRQ_W 4
`define SFQ_IRQ_FULL_BIT 0
`define SFQ_IRQ_EMPTY_BIT 1
`define SFQ_IRQ_OVF_BIT 2
`define SFQ_IRQ_UNF_BIT 3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SFQ_GRAY_ZERO 2'h0
`define SFQ_IRQ_MASK_RST 4'h0
`define SFQ_EMPTY_RST 1'h1

`endif

// [design/sfq_pkg.sv]
// types shared by the common-clock fifo
`default_nettype none

package sfq_pkg;
  `include "sfq_cfg.svh"

  // ----------------------------------------------------------------------------
  // producer side carrier
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [`SFQ_DATA_W-1:0] data;
  } sfq_wr_t;

  // ----------------------------------------------------------------------------
  // apb request carrier
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`SFQ_PADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } sfq_apb_req_t;

  // ----------------------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [`SFQ_DEPTH-1:0][`SFQ_DATA_W-1:0] mem;
    logic [1:0] wr_hi;
    logic [1:0] wr_lo;
    logic [1:0] rd_hi;
    logic [1:0] rd_lo;
    logic dir;
    logic full;
    logic empty;
    logic [`SFQ_DATA_W-1:0] dout;
    logic [`SFQ_IRQ_W-1:0] irq_stat;
    logic [`SFQ_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfq_state_t;
endpackage

`default_nettype wire

// [testbench/sfq_peer.sv]
// producer and consumer model facing the fifo data ports
`default_nettype none
module sfq_peer (
  input wire logic full,
  input wire logic empty,
  input wire logic push,
  input wire logic pop,
  input wire logic brk,
  input wire logic [15:0] din,
  output var sfq_pkg::sfq_wr_t wr,
  output logic rd_en
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfq_pkg::*;
  // brk lets one scenario write into a full fifo; idle data is inverted, not held
  assign wr = '{en: push && (!full || brk), data: push ? din : ~din};
  assign rd_en = pop && !empty;
endmodule
`default_nettype wire

// [testbench/sfq_fifo_chk.sv]
// port assertions for the fifo
`default_nettype none
module sfq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire sfq_pkg::sfq_apb_req_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sfq_pkg::sfq_wr_t wr,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic full,
  input wire logic empty,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import sfq_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic bus_wr;
  logic [4:0] cnt_ff;
  assign bus_wr = apb.psel && apb.penable && apb.pwrite && pready;
  // occupancy mirror; flush is the only other way to empty
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_ff <= 5'h0;
    else if (bus_wr && apb.paddr == 12'h000 && apb.pwdata[0]) cnt_ff <= 5'h0;
    else cnt_ff <= cnt_ff + 5'(wr.en && !full) - 5'(rd_en && !empty);
  end
  a_count_flags: assert property (full == (cnt_ff == 5'h10) && empty == (cnt_ff == 5'h0))
    else $error("flags disagree with occupancy");
  a_full_rise: assert property ($rose(full) |-> $past(wr.en) && !$past(rd_en))
    else $error("full rose without a write");
  a_empty_rise: assert property ($rose(empty) |-> $past(rd_en) || $past(bus_wr))
    else $error("empty rose without a read");
  a_full_drop: assert property (full && rd_en |=> !full)
    else $error("full kept after read");
  a_empty_drop: assert property (empty && wr.en && !bus_wr |=> !empty)
    else $error("empty kept after write");
  a_write_through: assert property (empty && wr.en && !bus_wr |=> rd_data == $past(wr.data))
    else $error("first word not shown");
  a_idle_hold: assert property (!wr.en && !rd_en && !apb.psel |=> $stable({full, empty, rd_data}))
    else $error("state moved while idle");
  a_refuse_full: assert property (full && wr.en && !rd_en && !apb.psel |=> full && $stable(rd_data))
    else $error("write accepted while full");
  cover property (full && rd_en);
  cover property (empty && wr.en);
  cover property ($rose(irq));
endmodule
bind sfq_fifo sfq_chk u_chk(.pclk, .presetn, .apb, .prdata, .pready, .pslverr, .wr, .rd_en,
  .rd_data, .full, .empty, .irq);
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the common-clock fifo
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfq_pkg::*;
  logic pclk = 0, presetn = 0, rd_en, full, empty, irq, pready, pslverr, e;
  logic push = 0, pop = 0, brk = 0;
  logic [31:0] prdata, q;
  logic [15:0] rd_data, din = 16'h0;
  sfq_apb_req_t apb = '0;
  sfq_wr_t wr;
  int fail_count = 0, samples_checked = 0, n = 0;
  logic [15:0] exp_q[$];
  sfq_fifo u_dut(.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr(wr), .rd_en(rd_en), .rd_data(rd_data), .full(full), .empty(empty),
    .irq(irq));
  sfq_peer u_peer(.full(full), .empty(empty), .push(push), .pop(pop), .brk(brk), .din(din),
    .wr(wr), .rd_en(rd_en));
  initial forever #12.5 pclk = ~pclk;
  // ---
  // shared tasks
  // ---
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", s, x, g);
    end
  endtask
  task wrap_up;
    $display("checks %0d fails %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk) apb.penable <= 1'b1;
    // look at ready between edges so the sampling edge is not raced
    do @(negedge pclk); while (pready !== 1'b1);
    @(posedge pclk);
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask
  // checks the state left by the previous edge, then books what the next edge does
  task step(input logic p, input logic o, input logic b);
    int sz;
    @(posedge pclk);
    push <= p;
    pop <= o;
    brk <= b;
    din <= 16'hA5C0 ^ 16'(n);
    @(negedge pclk);
    // a write into a full fifo is refused even with a read at the same edge
    sz = exp_q.size();
    chk("full", 32'(sz == 16), 32'(full));
    chk("empty", 32'(sz == 0), 32'(empty));
    if (o && sz > 0) begin
      chk("rd_data", 32'(exp_q[0]), 32'(rd_data));
      void'(exp_q.pop_front());
    end
    if (p && sz < 16) begin
      exp_q.push_back(din);
      n++;
    end
  endtask
  // ---
  // scenarios
  // ---
  task t_fill;
    step(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 17; i++) step(1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    $display("test fill done");
  endtask
  task t_irq;
    bus(1'b1, 12'h00C, 32'h4);
    step(1'b1, 1'b0, 1'b1);
    step(1'b0, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    chk("irq", 32'h1, 32'(irq));
    bus(1'b0, 12'h008, 32'h0);
    chk("irq_stat", 32'h5, q);
    step(1'b0, 1'b0, 1'b0);
    chk("irq", 32'h0, 32'(irq));
    bus(1'b0, 12'h010, 32'h0);
    chk("pslverr", 32'h1, 32'(e));
    $display("test irq done");
  endtask
  task t_drain;
    for (int i = 0; i < 16; i++) step(1'b0, 1'b1, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    $display("test drain done");
  endtask
  // offset pointers sweep ahead and opposite quadrants; the refill adds write behind read, then flush
  task t_wrap;
    for (int i = 0; i < 5; i++) step(1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 20; i++) step(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 5; i++) step(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 16; i++) step(1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b0, 1'b0);
    bus(1'b1, 12'h000, 32'h1);
    exp_q.delete();
    step(1'b0, 1'b0, 1'b0);
    bus(1'b0, 12'h004, 32'h0);
    chk("stat", 32'h1, q);
    $display("test wrap done");
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_fill;
    t_irq;
    t_drain;
    t_wrap;
    wrap_up;
  end
  initial begin
    #20us;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
